//--- shared/rtmc_pkg.sv
`default_nettype none
package rtmc_pkg;

   localparam int CLK_NS     = 50;
   localparam int TWRESP_NS  = 200000;
   localparam int TPROG_NS   = 5000000;
   localparam int TWRESP_CYC = (TWRESP_NS + CLK_NS - 1) / CLK_NS;
   localparam int TPROG_CYC  = (TPROG_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [3:0] CMD_READ_PAGE   = 4'hc;
   localparam logic [3:0] CMD_READ_BLOCK  = 4'hd;
   localparam logic [3:0] CMD_WRITE_PAGE  = 4'h8;
   localparam logic [3:0] CMD_WRITE_BLOCK = 4'h9;
   localparam logic [3:0] CMD_QUIET       = 4'h7;

   localparam int CMD_BITS    = 20;
   localparam int DATA_BITS   = 40;
   localparam int PAGE_BITS   = 32;
   localparam int CRC_BITS    = 8;
   localparam int PAGES       = 64;
   localparam int PAGE_AW     = 6;
   localparam int BLOCK_PAGES = 4;
   localparam int WAIT_W      = 20;

   localparam logic [7:0] CRC_POLY   = 8'h1d;
   localparam logic [7:0] CRC_PRESET = 8'hff;
   localparam logic [7:0] CRC_GOOD   = 8'h00;

   typedef struct packed {
      logic valid;
      logic data;
      logic eof;
   } rtmc_rx_s;

   typedef struct packed {
      logic valid;
      logic sof;
      logic data;
      logic last;
   } rtmc_tx_s;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RESP_WAIT,
      ST_TX,
      ST_FETCH,
      ST_DATA_WAIT,
      ST_PROG,
      ST_QUIET
   } rtmc_state_e;

   typedef enum logic [1:0] {
      PH_SOF,
      PH_WORD,
      PH_CRC,
      PH_ACK
   } rtmc_phase_e;

   // Advances the checksum by one bit, most significant bit first.
   function automatic logic [7:0] crcStep(input logic [7:0] crc, input logic b);
      crcStep = {crc[6:0], 1'b0} ^ ((crc[7] ^ b) ? CRC_POLY : 8'h00);
   endfunction

   // Maps a stored page word to link order and back: byte 0 goes first.
   function automatic logic [31:0] byteSwap(input logic [31:0] w);
      byteSwap = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

endpackage
`default_nettype wire

//--- rtl/rtmc_page_mem.sv
`timescale 1ns/1ns
`default_nettype none
module rtmc_page_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 64,
   parameter int AW    = 6
) (
   input  wire logic             clk_sys,
   input  wire logic             writeEn,
   input  wire logic [AW-1:0]    writeAddr,
   input  wire logic [WIDTH-1:0] writeData,
   input  wire logic [AW-1:0]    readAddr,
   output var  logic [WIDTH-1:0] readData
);

   if ((1 << AW) < DEPTH) begin : g_bad_aw
      $error("Address width too small for depth.");
   end

   logic [WIDTH-1:0] mem [DEPTH];

   // Page store with registered read data.
   always_ff @(posedge clk_sys) begin
      if (writeEn) begin
         mem[writeAddr] <= writeData;
      end
      readData <= mem[readAddr];
   end

endmodule
`default_nettype wire

//--- rtl/rtmc_core.sv
`timescale 1ns/1ns
`default_nettype none
module rtmc_core #(
   parameter int TWRESP_CYCLES = rtmc_pkg::TWRESP_CYC,
   parameter int TPROG_CYCLES  = rtmc_pkg::TPROG_CYC
) (
   input  wire logic               clk_sys,
   input  wire logic               reset,
   input  wire logic               fieldOn,
   input  wire logic               selected,
   input  wire rtmc_pkg::rtmc_rx_s rxIn,
   input  wire logic               txReady,
   output var  rtmc_pkg::rtmc_tx_s txOut,
   output var  logic               quietState
);

   if (TWRESP_CYCLES < 2 || TPROG_CYCLES < TWRESP_CYCLES ||
       TPROG_CYCLES >= (1 << rtmc_pkg::WAIT_W)) begin : g_bad_time
      $error("Timing counts out of range.");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Field detection and receive shifter.

   logic                       fieldMeta_q;
   logic                       fieldOk_q;
   rtmc_pkg::rtmc_state_e      state_q;
   rtmc_pkg::rtmc_phase_e      phase_q;
   logic [39:0]                rxShift_q;
   logic [5:0]                 rxCnt_q;
   logic [7:0]                 rxCrc_q;
   logic [rtmc_pkg::WAIT_W-1:0] waitCnt_q;
   logic [5:0]                 pageAddr_q;
   logic [2:0]                 pagesLeft_q;
   logic [2:0]                 wrLeft_q;
   logic                       replyAck_q;
   logic                       toQuiet_q;
   logic [4:0]                 bitCnt_q;
   logic [31:0]                txShift_q;
   logic [7:0]                 txCrc_q;
   logic [31:0]                memRData;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fieldMeta_q <= 1'b0;
         fieldOk_q   <= 1'b0;
      end else begin
         fieldMeta_q <= fieldOn;
         fieldOk_q   <= fieldMeta_q;
      end
   end

   wire rxOpen   = state_q == rtmc_pkg::ST_IDLE || state_q == rtmc_pkg::ST_DATA_WAIT;
   wire rxTake   = rxOpen && rxIn.valid && !rxIn.eof;
   wire crcOk    = rxCrc_q == rtmc_pkg::CRC_GOOD;
   wire cmdOk    = rxIn.eof && crcOk && rxCnt_q == 6'(rtmc_pkg::CMD_BITS);
   wire dataOk   = rxIn.eof && crcOk && rxCnt_q == 6'(rtmc_pkg::DATA_BITS);
   wire [3:0] cmdCode = rxShift_q[19:16];
   wire [5:0] cmdAddr = rxShift_q[13:8];
   wire [2:0] blockSpan = 3'(rtmc_pkg::BLOCK_PAGES) - {1'b0, cmdAddr[1:0]};
   wire idleEof  = state_q == rtmc_pkg::ST_IDLE && rxIn.eof;
   wire cmdTake  = idleEof && cmdOk && selected;
   wire memWe    = state_q == rtmc_pkg::ST_DATA_WAIT && dataOk;
   wire [31:0] memWData = rtmc_pkg::byteSwap(rxShift_q[39:8]);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rxShift_q <= 40'h00_0000_0000;
         rxCnt_q   <= 6'h00;
         rxCrc_q   <= rtmc_pkg::CRC_PRESET;
      end else if (!rxOpen || rxIn.eof) begin
         rxCnt_q   <= 6'h00;
         rxCrc_q   <= rtmc_pkg::CRC_PRESET;
      end else if (rxTake) begin
         rxShift_q <= {rxShift_q[38:0], rxIn.data};
         rxCnt_q   <= (rxCnt_q == 6'h3f) ? rxCnt_q : rxCnt_q + 6'h01;
         rxCrc_q   <= rtmc_pkg::crcStep(rxCrc_q, rxIn.data);
      end
   end

   rtmc_page_mem #(
      .WIDTH (rtmc_pkg::PAGE_BITS),
      .DEPTH (rtmc_pkg::PAGES),
      .AW    (rtmc_pkg::PAGE_AW)
   ) u_mem (
      .clk_sys   (clk_sys),
      .writeEn   (memWe),
      .writeAddr (pageAddr_q),
      .writeData (memWData),
      .readAddr  (pageAddr_q),
      .readData  (memRData)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Command sequencer and reply shifter.

   wire txGo     = !txOut.valid || txReady;
   wire txDone   = txOut.valid && txOut.last && txReady;
   wire waitDone = waitCnt_q == '0;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q     <= rtmc_pkg::ST_IDLE;
         phase_q     <= rtmc_pkg::PH_SOF;
         waitCnt_q   <= '0;
         pageAddr_q  <= 6'h00;
         pagesLeft_q <= 3'h0;
         wrLeft_q    <= 3'h0;
         replyAck_q  <= 1'b0;
         toQuiet_q   <= 1'b0;
         bitCnt_q    <= 5'h00;
         txShift_q   <= 32'h0000_0000;
         txCrc_q     <= rtmc_pkg::CRC_PRESET;
         txOut       <= '0;
         quietState  <= 1'b0;
      end else if (!fieldOk_q) begin
         state_q    <= rtmc_pkg::ST_IDLE;
         wrLeft_q   <= 3'h0;
         toQuiet_q  <= 1'b0;
         txOut      <= '0;
         quietState <= 1'b0;
      end else begin
         case (state_q)
            rtmc_pkg::ST_IDLE: begin
               if (cmdTake) begin
                  pageAddr_q <= cmdAddr;
                  waitCnt_q  <= rtmc_pkg::WAIT_W'(TWRESP_CYCLES - 1);
                  state_q    <= rtmc_pkg::ST_RESP_WAIT;
                  case (cmdCode)
                     rtmc_pkg::CMD_READ_PAGE: begin
                        replyAck_q  <= 1'b0;
                        pagesLeft_q <= 3'h1;
                     end
                     rtmc_pkg::CMD_READ_BLOCK: begin
                        replyAck_q  <= 1'b0;
                        pagesLeft_q <= blockSpan;
                     end
                     rtmc_pkg::CMD_WRITE_PAGE: begin
                        replyAck_q <= 1'b1;
                        wrLeft_q   <= 3'h1;
                     end
                     rtmc_pkg::CMD_WRITE_BLOCK: begin
                        replyAck_q <= 1'b1;
                        wrLeft_q   <= blockSpan;
                     end
                     rtmc_pkg::CMD_QUIET: begin
                        replyAck_q <= 1'b1;
                        toQuiet_q  <= 1'b1;
                     end
                     default: begin
                        state_q <= rtmc_pkg::ST_IDLE;
                     end
                  endcase
               end
            end
            rtmc_pkg::ST_RESP_WAIT: begin
               waitCnt_q <= waitCnt_q - 1'b1;
               if (waitDone) begin
                  state_q <= rtmc_pkg::ST_TX;
                  phase_q <= rtmc_pkg::PH_SOF;
               end
            end
            rtmc_pkg::ST_DATA_WAIT: begin
               if (rxIn.eof) begin
                  if (dataOk) begin
                     pageAddr_q <= pageAddr_q + 6'h01;
                     wrLeft_q   <= wrLeft_q - 3'h1;
                     waitCnt_q  <= rtmc_pkg::WAIT_W'(TPROG_CYCLES - 1);
                     state_q    <= rtmc_pkg::ST_PROG;
                  end else begin
                     wrLeft_q <= 3'h0;
                     state_q  <= rtmc_pkg::ST_IDLE;
                  end
               end
            end
            rtmc_pkg::ST_PROG: begin
               waitCnt_q <= waitCnt_q - 1'b1;
               if (waitDone) begin
                  state_q <= rtmc_pkg::ST_TX;
                  phase_q <= rtmc_pkg::PH_SOF;
               end
            end
            rtmc_pkg::ST_FETCH: begin
               if (txReady) begin
                  txOut.valid <= 1'b0;
               end
               waitCnt_q <= waitCnt_q - 1'b1;
               if (waitDone) begin
                  txShift_q <= rtmc_pkg::byteSwap(memRData);
                  state_q   <= rtmc_pkg::ST_TX;
               end
            end
            rtmc_pkg::ST_TX: begin
               if (txDone) begin
                  txOut <= '0;
                  if (toQuiet_q) begin
                     state_q    <= rtmc_pkg::ST_QUIET;
                     quietState <= 1'b1;
                  end else if (wrLeft_q != 3'h0) begin
                     state_q <= rtmc_pkg::ST_DATA_WAIT;
                  end else begin
                     state_q <= rtmc_pkg::ST_IDLE;
                  end
               end else if (txGo && !(txOut.valid && txOut.last)) begin
                  bitCnt_q <= bitCnt_q + 5'h01;
                  case (phase_q)
                     rtmc_pkg::PH_SOF: begin
                        txOut     <= '{valid: 1'b1, sof: 1'b1, data: 1'b0, last: 1'b0};
                        bitCnt_q  <= 5'h00;
                        txCrc_q   <= rtmc_pkg::CRC_PRESET;
                        txShift_q <= rtmc_pkg::byteSwap(memRData);
                        phase_q   <= replyAck_q ? rtmc_pkg::PH_ACK : rtmc_pkg::PH_WORD;
                     end
                     rtmc_pkg::PH_ACK: begin
                        txOut <= '{valid: 1'b1, sof: 1'b0, data: bitCnt_q[0],
                                   last: bitCnt_q[0]};
                     end
                     rtmc_pkg::PH_WORD: begin
                        txOut     <= '{valid: 1'b1, sof: 1'b0, data: txShift_q[31], last: 1'b0};
                        txShift_q <= {txShift_q[30:0], 1'b0};
                        txCrc_q   <= rtmc_pkg::crcStep(txCrc_q, txShift_q[31]);
                        if (bitCnt_q == 5'h1f) begin
                           if (pagesLeft_q == 3'h1) begin
                              phase_q <= rtmc_pkg::PH_CRC;
                           end else begin
                              pagesLeft_q <= pagesLeft_q - 3'h1;
                              pageAddr_q  <= pageAddr_q + 6'h01;
                              waitCnt_q   <= rtmc_pkg::WAIT_W'(1);
                              state_q     <= rtmc_pkg::ST_FETCH;
                           end
                        end
                     end
                     rtmc_pkg::PH_CRC: begin
                        txOut   <= '{valid: 1'b1, sof: 1'b0, data: txCrc_q[7],
                                     last: bitCnt_q[2:0] == 3'h7};
                        txCrc_q <= {txCrc_q[6:0], 1'b0};
                     end
                     default: begin
                        phase_q <= rtmc_pkg::PH_SOF;
                     end
                  endcase
               end
            end
            rtmc_pkg::ST_QUIET: begin
               state_q <= rtmc_pkg::ST_QUIET;
            end
            default: begin
               state_q <= rtmc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   logic [rtmc_pkg::WAIT_W-1:0] sinceEof_q;
   logic [8:0]                  symCnt_q;
   logic [2:0]                  pagesAtCmd_q;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sinceEof_q   <= '0;
         symCnt_q     <= 9'h000;
         pagesAtCmd_q <= 3'h0;
      end else begin
         sinceEof_q <= rxIn.eof ? '0 :
                       (&sinceEof_q ? sinceEof_q : sinceEof_q + 1'b1);
         if (txOut.valid && txReady) begin
            symCnt_q <= txOut.sof ? 9'h000 : symCnt_q + 9'h001;
         end
         if (cmdTake) begin
            pagesAtCmd_q <= (cmdCode == rtmc_pkg::CMD_READ_BLOCK) ? blockSpan : 3'h1;
         end
      end
   end

   property p_reply_wait;
      @(posedge clk_sys) disable iff (reset)
      (txOut.valid && txOut.sof) |-> sinceEof_q >= rtmc_pkg::WAIT_W'(TWRESP_CYCLES);
   endproperty
   a_reply_wait: assert property (p_reply_wait) else $error("Reply before response wait.");

   property p_unselected;
      @(posedge clk_sys) disable iff (reset)
      (idleEof && !selected && fieldOk_q) |=> state_q == rtmc_pkg::ST_IDLE;
   endproperty
   a_unselected: assert property (p_unselected) else $error("Command taken while unselected.");

   property p_bad_crc;
      @(posedge clk_sys) disable iff (reset)
      (idleEof && !crcOk) |=> state_q == rtmc_pkg::ST_IDLE ##1 !txOut.valid;
   endproperty
   a_bad_crc: assert property (p_bad_crc) else $error("Bad checksum frame answered.");

   property p_quiet_silent;
      @(posedge clk_sys) disable iff (reset)
      state_q == rtmc_pkg::ST_QUIET |-> !txOut.valid && quietState;
   endproperty
   a_quiet_silent: assert property (p_quiet_silent) else $error("Output while quiet.");

   property p_quiet_entry;
      @(posedge clk_sys) disable iff (reset)
      $rose(state_q == rtmc_pkg::ST_QUIET) |-> $past(txDone) && replyAck_q;
   endproperty
   a_quiet_entry: assert property (p_quiet_entry) else $error("Quiet without ack.");

   property p_ack_code;
      @(posedge clk_sys) disable iff (reset)
      (txOut.valid && !txOut.sof && replyAck_q) |-> txOut.data == txOut.last;
   endproperty
   a_ack_code: assert property (p_ack_code) else $error("Ack is not 01.");

   property p_read_length;
      @(posedge clk_sys) disable iff (reset)
      (txDone && !replyAck_q) |-> symCnt_q + 9'h001 == {pagesAtCmd_q, 5'h00} + 9'h008;
   endproperty
   a_read_length: assert property (p_read_length) else $error("Read reply length wrong.");

   property p_byte_order;
      @(posedge clk_sys) disable iff (reset)
      memWe |-> memWData[7:0] == rxShift_q[39:32] && memWData[31:24] == rxShift_q[15:8];
   endproperty
   a_byte_order: assert property (p_byte_order) else $error("Write byte order wrong.");

   property p_block_step;
      @(posedge clk_sys) disable iff (reset)
      memWe |=> state_q == rtmc_pkg::ST_PROG && wrLeft_q == $past(wrLeft_q) - 3'h1;
   endproperty
   a_block_step: assert property (p_block_step) else $error("Write step wrong.");

   property p_block_span;
      @(posedge clk_sys) disable iff (reset)
      (cmdTake && cmdCode == rtmc_pkg::CMD_READ_BLOCK) |=>
         pagesLeft_q + {1'b0, $past(cmdAddr[1:0])} == 3'h4;
   endproperty
   a_block_span: assert property (p_block_span) else $error("Block span wrong.");

   c_read: cover property (@(posedge clk_sys) disable iff (reset) txDone && !replyAck_q);
   c_write: cover property (@(posedge clk_sys) disable iff (reset) memWe);
   c_quiet: cover property (@(posedge clk_sys) disable iff (reset)
                            $rose(state_q == rtmc_pkg::ST_QUIET));

endmodule
`default_nettype wire

//--- verif/rtmc_reader.sv
`timescale 1ns/1ns
`default_nettype none
// Reader model: frames commands and write data, and collects reply symbols.
module rtmc_reader #(
   parameter int TWSC = 4
) (
   input  wire logic               clk_sys,
   input  wire rtmc_pkg::rtmc_tx_s txIn,
   output var  logic               txReady,
   output var  rtmc_pkg::rtmc_rx_s rxOut
);
   logic [135:0] reply;
   logic         done;
   logic         slow;
   int           nBits;
   int           cyc;
   int           eofCyc;
   int           sofCyc;

   initial begin
      rxOut = '0;
      slow = 1'b0;
      done = 1'b0;
      cyc = 0;
   end

   // A slow reader accepts a reply symbol only every other cycle.
   assign txReady = ~slow | cyc[0];

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (txIn.valid && txReady) begin
         if (txIn.sof) begin
            nBits <= 0;
            sofCyc <= cyc;
         end else begin
            reply <= {reply[134:0], txIn.data};
            nBits <= nBits + 1;
         end
         if (txIn.last) done <= 1'b1;
      end
   end

   function automatic logic [7:0] crcOf(input logic [127:0] v, input int n);
      logic [7:0] c;
      c = 8'hff;
      for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h1d : 8'h00);
      return c;
   endfunction

   // Sends n bits, the checksum (spoiled if bad) and end-of-frame.
   task automatic sendBits(input logic [39:0] v, input int n, input logic bad);
      logic [47:0] f;
      f = {v, crcOf({88'h0, v}, n) ^ {7'h0, bad}};
      done = 1'b0;
      reply = '0;
      for (int i = n + 7; i >= 0; i--) begin
         @(posedge clk_sys);
         #1 rxOut = '{valid: 1'b1, data: f[i], eof: 1'b0};
      end
      @(posedge clk_sys);
      #1 rxOut = '{valid: 1'b0, data: ~rxOut.data, eof: 1'b1};
      eofCyc = cyc;
      @(posedge clk_sys);
      #1 rxOut = '{valid: 1'b0, data: ~rxOut.data, eof: 1'b0};
   endtask

   task automatic sendCmd(input logic [3:0] code, input logic [5:0] addr, input logic bad);
      sendBits({28'h0, code, 2'b00, addr}, 12, bad);
   endtask

   task automatic sendData(input logic [31:0] w);
      repeat (TWSC) @(posedge clk_sys);
      sendBits({8'h0, w[7:0], w[15:8], w[23:16], w[31:24]}, 32, 1'b0);
   endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int          TW = 8;
   localparam int          TP = 20;
   localparam logic [31:0] W1 = 32'h1234abcd;
   localparam logic [31:0] W2 = 32'h80c1e2f7;
   localparam logic [31:0] W3 = 32'h5a0f9633;
   logic                   clk_sys;
   logic                   reset;
   logic                   fieldOn;
   logic                   selected;
   logic                   txReady;
   logic                   quietState;
   rtmc_pkg::rtmc_rx_s     rxIn;
   rtmc_pkg::rtmc_tx_s     txOut;
   int                     fails;
   int                     n_tests;

   rtmc_core #(.TWRESP_CYCLES(TW), .TPROG_CYCLES(TP)) rtmc_core_i (
      .clk_sys(clk_sys), .reset(reset), .fieldOn(fieldOn), .selected(selected),
      .rxIn(rxIn), .txReady(txReady), .txOut(txOut), .quietState(quietState));
   rtmc_reader rtmc_reader_i (
      .clk_sys(clk_sys), .txIn(txOut), .txReady(txReady), .rxOut(rxIn));

   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] sw(input logic [31:0] w);
      return {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   task automatic check(input logic ok);
      n_tests++;
      if (ok !== 1'b1) begin
         fails++;
         $display("MISMATCH %0t unexpected reply or state", $time);
      end
   endtask

   task automatic expectReply(input logic [135:0] e, input int n);
      int k;
      k = 0;
      while (rtmc_reader_i.done !== 1'b1 && k < 2000) begin
         @(posedge clk_sys);
         k++;
      end
      #2;
      check(rtmc_reader_i.done === 1'b1 && rtmc_reader_i.nBits == n
         && rtmc_reader_i.reply === e
         && rtmc_reader_i.sofCyc - rtmc_reader_i.eofCyc >= TW + 1);
   endtask

   task automatic noReply;
      repeat (TW + TP + 60) @(posedge clk_sys);
      check(rtmc_reader_i.done === 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_page;
      rtmc_reader_i.sendCmd(4'h8, 6'h05, 1'b0);
      expectReply(136'h1, 2);
      rtmc_reader_i.sendData(W1);
      expectReply(136'h1, 2);
      rtmc_reader_i.slow = 1'b1;
      rtmc_reader_i.sendCmd(4'hc, 6'h05, 1'b0);
      expectReply({sw(W1), rtmc_reader_i.crcOf({96'h0, sw(W1)}, 32)}, 40);
      rtmc_reader_i.slow = 1'b0;
   endtask

   task automatic t_block;
      rtmc_reader_i.sendCmd(4'h9, 6'h0e, 1'b0);
      expectReply(136'h1, 2);
      rtmc_reader_i.sendData(W2);
      expectReply(136'h1, 2);
      rtmc_reader_i.sendData(W3);
      expectReply(136'h1, 2);
      rtmc_reader_i.sendData(W1);
      noReply();
      rtmc_reader_i.sendCmd(4'hd, 6'h0e, 1'b0);
      expectReply({sw(W2), sw(W3),
         rtmc_reader_i.crcOf({64'h0, sw(W2), sw(W3)}, 64)}, 72);
   endtask

   task automatic t_refuse;
      rtmc_reader_i.sendCmd(4'hc, 6'h05, 1'b1);
      noReply();
      #1 selected = 1'b0;
      rtmc_reader_i.sendCmd(4'hc, 6'h05, 1'b0);
      noReply();
      rtmc_reader_i.sendCmd(4'h8, 6'h05, 1'b0);
      noReply();
      #1 selected = 1'b1;
      rtmc_reader_i.sendCmd(4'h3, 6'h05, 1'b0);
      noReply();
   endtask

   task automatic t_quiet;
      rtmc_reader_i.sendCmd(4'h7, 6'h3f, 1'b0);
      expectReply(136'h1, 2);
      repeat (2) @(posedge clk_sys);
      #1 check(quietState === 1'b1);
      rtmc_reader_i.sendCmd(4'hc, 6'h05, 1'b0);
      noReply();
      #1 fieldOn = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 check(quietState === 1'b0);
      fieldOn = 1'b1;
   endtask

   task automatic end_sim;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      reset = 1'b1;
      fieldOn = 1'b1;
      selected = 1'b1;
      fails = 0;
      n_tests = 0;
      repeat (6) @(posedge clk_sys);
      #1 reset = 1'b0;
      repeat (3) @(posedge clk_sys);
      t_page();
      t_block();
      t_refuse();
      t_quiet();
      end_sim();
   end

   initial begin
      #1500000;
      fails++;
      end_sim();
   end
endmodule
`default_nettype wire
